// ### hw/host_event_pkg.sv
// constants of the host event status block
// assumes a byte-wide register view carried in the lowest lane of a 32-bit wishbone bus
`default_nettype none
package host_event_pkg;
    // ---------------------------------------------------------------
    // register map (printed offsets are indices, byte address = 4x)
    // ---------------------------------------------------------------
    localparam logic [7:0] IDX_PORT_EVENT_0 = 8'he0;
    localparam logic [7:0] IDX_PORT_EVENT_1 = 8'he1;
    localparam logic [7:0] IDX_BUFFER_EVENT = 8'he2;
    localparam logic [7:0] IDX_PORT_ENABLE_0 = 8'he8;
    localparam logic [7:0] IDX_PORT_ENABLE_1 = 8'he9;
    localparam logic [7:0] IDX_BUFFER_ENABLE = 8'hea;
    // ---------------------------------------------------------------
    // implemented bit masks and reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] MASK_PORT_EVENT_0 = 8'h1f;
    localparam logic [7:0] MASK_PORT_EVENT_1 = 8'h0f;
    localparam logic [7:0] MASK_BUFFER_EVENT = 8'h77;
    localparam logic [7:0] RESET_EVENT = 8'h00;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int BIT_CABLE_ATTACH = 4;
    localparam int BIT_CABLE_DETACH = 3;
    localparam int BIT_WAKEUP = 2;
    localparam int BIT_CHIRP_GOOD = 1;
    localparam int BIT_CHIRP_BAD = 0;
    localparam int BIT_DISABLED_DONE = 3;
    localparam int BIT_RESUME_DONE = 2;
    localparam int BIT_SUSPEND_DONE = 1;
    localparam int BIT_BUS_RESET_DONE = 0;
    localparam int BIT_DISK_DONE = 6;
    localparam int BIT_DMA1_DONE = 5;
    localparam int BIT_DMA0_DONE = 4;
    localparam int BIT_HOLDS_DATA = 2;
    localparam int BIT_FULL = 1;
    localparam int BIT_DRAINED = 0;
    // ---------------------------------------------------------------
    // mode codes seen on the side inputs
    // ---------------------------------------------------------------
    localparam logic [1:0] SPEED_HIGH = 2'h2;
    localparam logic [1:0] BUS_STATE_SUSPEND = 2'h2;
    localparam logic [3:0] AUTO_GO_DISABLED = 4'h1;
    localparam logic [3:0] AUTO_GO_RESUME = 4'h2;
    localparam logic [3:0] AUTO_GO_SUSPEND = 4'h3;
    localparam logic [3:0] AUTO_GO_RESET = 4'h4;
    localparam int DMA_COUNT = 3;
    localparam int DMA_DISK = 2;
    localparam int DMA_SECOND = 1;
    localparam int DMA_FIRST = 0;
endpackage
`default_nettype wire

// ### hw/event_latch.sv
// one register of sticky write-one-to-clear cause bits
// assumes set pulses and clear strobes are synchronous to clk
`default_nettype none
module event_latch
    import host_event_pkg::*;
#(
    parameter logic [7:0] MASK = 8'hff
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // events and clears
    input wire logic [7:0] setBits,
    input wire logic [7:0] clearBits,
    input wire logic clearLock,
    // state
    output logic [7:0] causeBits
);
    typedef struct packed {
        logic [7:0] cause;
    } latch_s;
    latch_s state_q, state_d;

    always_comb begin
        state_d = state_q;
        for (int i = 0; i < 8; i++) begin
            if (MASK[i] && setBits[i]) begin
                state_d.cause[i] = 1'b1;
            end else if (clearBits[i] && !clearLock) begin
                state_d.cause[i] = 1'b0;
            end
        end
        state_d.cause = state_d.cause & MASK;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= '{cause: RESET_EVENT};
        end else begin
            state_q <= state_d;
        end
    end

    assign causeBits = state_q.cause;
endmodule
`default_nettype wire

// ### hw/dma_done_tracker.sv
// tracks one transfer engine until its completion may be reported
// assumes transferEnd is a one-cycle pulse and bufferEmpty a level
`default_nettype none
module dma_done_tracker
    import host_event_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // engine side
    input wire logic transferEnd,
    input wire logic directionIn,
    input wire logic bufferEmpty,
    // result
    output logic donePulse
);
    typedef struct packed {
        logic waiting;
        logic done;
    } track_s;
    track_s state_q, state_d;

    always_comb begin
        state_d = state_q;
        state_d.done = 1'b0;
        // in direction waits for the buffer to drain toward the host side
        if (transferEnd && !directionIn) begin
            state_d.done = 1'b1;
        end else if (transferEnd || state_q.waiting) begin
            state_d.waiting = !bufferEmpty;
            state_d.done = bufferEmpty;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign donePulse = state_q.done;
endmodule
`default_nettype wire

// ### hw/usb_host_event_status.sv
// host event cause registers behind a classic wishbone slave
// assumes detectors outside deliver one-cycle event pulses on clk
//
// Implementation choice: the Wishbone register port.
`default_nettype none
module usb_host_event_status
    import host_event_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // port detectors
    input wire logic cableAttachSeen,
    input wire logic cableDetachSeen,
    input wire logic wakeupRequestSeen,
    input wire logic chirpGoodSeen,
    input wire logic chirpBadSeen,
    // bus state machine
    input wire logic [3:0] automaticStateRequest,
    input wire logic autoStateDoneOk,
    input wire logic [1:0] linkSpeedSetting,
    input wire logic [1:0] hostBusState,
    // chip state
    input wire logic pllRunningState,
    input wire logic deviceActiveState,
    // transfer engines: disk, second, first
    input wire logic [2:0] transferEnd,
    input wire logic [2:0] transferDirIn,
    input wire logic [2:0] engineBufferEmpty,
    // status-joined channel buffer
    input wire logic statusJoinSelect,
    input wire logic joinedHoldsData,
    input wire logic joinedFull,
    input wire logic joinedEmpty,
    // interrupt
    output logic interruptOut_n
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
        logic [7:0] en0;
        logic [7:0] en1;
        logic [7:0] en2;
        logic irq_n;
        logic fullPrev;
        logic emptyPrev;
    } top_s;
    top_s state_q, state_d;

    logic [7:0] port0, port1, buf0;
    logic [7:0] set0, set1, set2;
    logic [7:0] clr0, clr1, clr2;
    logic [2:0] dmaDone;
    logic access, wrLow, hit;
    logic [7:0] index;
    logic [7:0] readByte;
    logic clearLock;
    logic detachAllowed;
    logic suspended;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    // ack is registered, so every access takes exactly one wait cycle
    assign access = wb_cyc_i && wb_stb_i && !state_q.ack && !state_q.err;
    assign index = wb_adr_i[9:2];
    assign wrLow = access && wb_we_i && wb_sel_i[0];
    assign hit = (wb_adr_i[31:10] == 22'h000000) && (wb_adr_i[1:0] == 2'h0)
        && (index == IDX_PORT_EVENT_0 || index == IDX_PORT_EVENT_1
        || index == IDX_BUFFER_EVENT || index == IDX_PORT_ENABLE_0
        || index == IDX_PORT_ENABLE_1 || index == IDX_BUFFER_ENABLE);

    assign clr0 = (wrLow && index == IDX_PORT_EVENT_0) ? wb_dat_i[7:0] : 8'h00;
    assign clr1 = (wrLow && index == IDX_PORT_EVENT_1) ? wb_dat_i[7:0] : 8'h00;
    assign clr2 = (wrLow && index == IDX_BUFFER_EVENT) ? wb_dat_i[7:0] : 8'h00;

    // clear lock in pll or device state
    assign clearLock = pllRunningState || deviceActiveState;
    // firmware must clear, then toggle enables, around host mode changes;
    // this block relies on it and does not gate enables itself
    // enable ordering left to firmware

    // ---------------------------------------------------------------
    // event sources
    // ---------------------------------------------------------------
    assign suspended = (hostBusState == BUS_STATE_SUSPEND);
    assign detachAllowed = !((linkSpeedSetting == SPEED_HIGH) && suspended);

    always_comb begin
        set0 = 8'h00;
        set1 = 8'h00;
        set2 = 8'h00;
        set0[BIT_CABLE_ATTACH] = cableAttachSeen;
        set0[BIT_CABLE_DETACH] = cableDetachSeen && detachAllowed;
        set0[BIT_WAKEUP] = wakeupRequestSeen && suspended;
        set0[BIT_CHIRP_GOOD] = chirpGoodSeen;
        set0[BIT_CHIRP_BAD] = chirpBadSeen;
        set1[BIT_DISABLED_DONE] = autoStateDoneOk && automaticStateRequest == AUTO_GO_DISABLED;
        set1[BIT_RESUME_DONE] = autoStateDoneOk && automaticStateRequest == AUTO_GO_RESUME;
        set1[BIT_SUSPEND_DONE] = autoStateDoneOk && automaticStateRequest == AUTO_GO_SUSPEND;
        set1[BIT_BUS_RESET_DONE] = autoStateDoneOk && automaticStateRequest == AUTO_GO_RESET;
        set2[BIT_DISK_DONE] = dmaDone[DMA_DISK];
        set2[BIT_DMA1_DONE] = dmaDone[DMA_SECOND];
        set2[BIT_DMA0_DONE] = dmaDone[DMA_FIRST];
        set2[BIT_HOLDS_DATA] = statusJoinSelect && joinedHoldsData;
        set2[BIT_FULL] = statusJoinSelect && joinedFull && !state_q.fullPrev;
        set2[BIT_DRAINED] = statusJoinSelect && joinedEmpty && !state_q.emptyPrev;
    end

    genvar g;
    generate
        for (g = 0; g < DMA_COUNT; g++) begin : gen_engine
            dma_done_tracker u_track (
                .clk(clk),
                .sys_rst(sys_rst),
                .transferEnd(transferEnd[g]),
                .directionIn(transferDirIn[g]),
                .bufferEmpty(engineBufferEmpty[g]),
                .donePulse(dmaDone[g])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // cause registers
    // ---------------------------------------------------------------
    event_latch #(.MASK(MASK_PORT_EVENT_0)) u_port0 (
        .clk(clk),
        .sys_rst(sys_rst),
        .setBits(set0),
        .clearBits(clr0),
        .clearLock(clearLock),
        .causeBits(port0)
    );

    event_latch #(.MASK(MASK_PORT_EVENT_1)) u_port1 (
        .clk(clk),
        .sys_rst(sys_rst),
        .setBits(set1),
        .clearBits(clr1),
        .clearLock(clearLock),
        .causeBits(port1)
    );

    // buffer causes are not locked by the chip state
    event_latch #(.MASK(MASK_BUFFER_EVENT)) u_buf (
        .clk(clk),
        .sys_rst(sys_rst),
        .setBits(set2),
        .clearBits(clr2),
        .clearLock(1'b0),
        .causeBits(buf0)
    );

    // ---------------------------------------------------------------
    // read mux and registered state
    // ---------------------------------------------------------------
    // reserved bits read zero
    always_comb begin
        case (index)
            IDX_PORT_EVENT_0: readByte = port0;
            IDX_PORT_EVENT_1: readByte = port1;
            IDX_BUFFER_EVENT: readByte = buf0;
            IDX_PORT_ENABLE_0: readByte = state_q.en0;
            IDX_PORT_ENABLE_1: readByte = state_q.en1;
            IDX_BUFFER_ENABLE: readByte = state_q.en2;
            default: readByte = 8'h00;
        endcase
    end

    always_comb begin
        state_d = state_q;
        state_d.ack = access && hit;
        state_d.err = access && !hit;
        state_d.rdata = (access && hit && !wb_we_i) ? {24'h000000, readByte} : 32'h00000000;
        if (wrLow && index == IDX_PORT_ENABLE_0) begin
            state_d.en0 = wb_dat_i[7:0] & MASK_PORT_EVENT_0;
        end
        if (wrLow && index == IDX_PORT_ENABLE_1) begin
            state_d.en1 = wb_dat_i[7:0] & MASK_PORT_EVENT_1;
        end
        if (wrLow && index == IDX_BUFFER_ENABLE) begin
            state_d.en2 = wb_dat_i[7:0] & MASK_BUFFER_EVENT;
        end
        state_d.irq_n = !(|(port0 & state_q.en0) || |(port1 & state_q.en1) || |(buf0 & state_q.en2));
        state_d.fullPrev = joinedFull;
        state_d.emptyPrev = joinedEmpty;
    end

    // emptyPrev starts high: a buffer that is already empty at reset is not a drain event
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= '{ack: 1'b0, err: 1'b0, rdata: 32'h00000000, en0: RESET_EVENT, en1: RESET_EVENT,
                en2: RESET_EVENT, irq_n: 1'b1, fullPrev: 1'b0, emptyPrev: 1'b1};
        end else begin
            state_q <= state_d;
        end
    end

    assign wb_ack_o = state_q.ack;
    assign wb_err_o = state_q.err;
    assign wb_dat_o = state_q.rdata;
    assign interruptOut_n = state_q.irq_n;
endmodule
`default_nettype wire

// ### testbench/host_event_checker.sv
// assertions on the ports of the host event status block
// assumes wb_adr_i[31:10] stays zero and one master on the bus
`default_nettype none
module host_event_checker
    import host_event_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // interrupt
    input wire logic interruptOut_n
);
    logic take, wrTake, causeIdx, mapped;
    logic [31:0] spare;
    logic [7:0] ix;
    assign ix = wb_adr_i[9:2];
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign wrTake = take && wb_we_i;
    assign causeIdx = ix inside {IDX_PORT_EVENT_0, IDX_PORT_EVENT_1, IDX_BUFFER_EVENT};
    assign mapped = causeIdx || ix inside {IDX_PORT_ENABLE_0, IDX_PORT_ENABLE_1, IDX_BUFFER_ENABLE};
    // bits of a cause read that have no cause behind them
    assign spare = ~{24'h0, ix == IDX_PORT_EVENT_0 ? MASK_PORT_EVENT_0
        : ix == IDX_PORT_EVENT_1 ? MASK_PORT_EVENT_1 : MASK_BUFFER_EVENT};
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    mapped_ack_a: assert property (take && mapped |=> wb_ack_o && !wb_err_o)
        else $error("mapped request not answered by ack");
    unmapped_err_a: assert property (take && !mapped |=> wb_err_o && !wb_ack_o)
        else $error("unmapped request not answered by err");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    err_single_a: assert property (wb_err_o |-> ##1 !wb_err_o)
        else $error("err held past one cycle");
    idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data driven outside ack");
    reserved_read_a: assert property (take && !wb_we_i && causeIdx |=> (wb_dat_o & $past(spare)) == 32'h0)
        else $error("reserved cause bit read as one");
    irq_hold_a: assert property (!interruptOut_n && !wrTake && !$past(wrTake) && !$past(wrTake, 2)
        |=> !interruptOut_n)
        else $error("interrupt released without a write");
    irq_release_a: assert property ($rose(interruptOut_n)
        |-> $past(wrTake) || $past(wrTake, 2) || $past(wrTake, 3))
        else $error("interrupt rose without a preceding write");
endmodule
`default_nettype wire

// ### testbench/usb_peer_model.sv
// model of the usb peripheral on the host port, seen through the line detectors
// assumes the bench names at most one line event per cycle on act
`default_nettype none
module usb_peer_model (
    // clock and command
    input wire logic clk,
    input wire logic [2:0] act,
    // detector pulses
    output logic cableAttachSeen,
    output logic cableDetachSeen,
    output logic wakeupRequestSeen,
    output logic chirpGoodSeen,
    output logic chirpBadSeen
);
    // one-cycle pulses: a level would keep re-setting a cleared cause
    always_ff @(posedge clk) begin
        cableAttachSeen <= act == 3'h1;
        cableDetachSeen <= act == 3'h2;
        wakeupRequestSeen <= act == 3'h3;
        chirpGoodSeen <= act == 3'h4;
        chirpBadSeen <= act == 3'h5;
    end
endmodule
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench of the host event status block
// assumes the package of the design is compiled first
`default_nettype none
module tb import host_event_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, sys_rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
    logic [3:0] wb_sel_i = 4'h1, automaticStateRequest = 4'h0, k, a;
    logic wb_ack_o, wb_err_o, interruptOut_n, autoStateDoneOk = 1'b0, pllRunningState = 1'b0, e;
    logic deviceActiveState = 1'b0, statusJoinSelect = 1'b1, joinedHoldsData = 1'b0;
    logic joinedFull = 1'b0, joinedEmpty = 1'b0;
    logic [1:0] linkSpeedSetting = 2'h0, hostBusState = 2'h0;
    logic [2:0] transferEnd = 3'h0, transferDirIn = 3'h0, engineBufferEmpty = 3'h0, act = 3'h0;
    logic cableAttachSeen, cableDetachSeen, wakeupRequestSeen, chirpGoodSeen, chirpBadSeen;
    logic [7:0] q, ix, ex;
    int bad_count = 0, cmp_count = 0, cycles = 0;
    localparam logic [7:0] IDXS [6] = '{IDX_PORT_EVENT_0, IDX_PORT_EVENT_1, IDX_BUFFER_EVENT,
        IDX_PORT_ENABLE_0, IDX_PORT_ENABLE_1, IDX_BUFFER_ENABLE};
    // row: kind, speed and bus state, aux code, register index, expected cause byte
    localparam logic [27:0] ROWS [17] = '{28'h100e010, 28'h200e008, 28'h320e004, 28'h400e002,
        28'h500e001, 28'h2a0e000, 28'h601e108, 28'h602e104, 28'h603e102, 28'h604e101,
        28'h704e240, 28'h702e220, 28'h701e210, 28'h800e204, 28'h900e202, 28'ha00e201,
        28'h300e000};
    usb_host_event_status dut (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .cableAttachSeen, .cableDetachSeen,
        .wakeupRequestSeen, .chirpGoodSeen, .chirpBadSeen, .automaticStateRequest, .autoStateDoneOk,
        .linkSpeedSetting, .hostBusState, .pllRunningState, .deviceActiveState, .transferEnd,
        .transferDirIn, .engineBufferEmpty, .statusJoinSelect, .joinedHoldsData, .joinedFull,
        .joinedEmpty, .interruptOut_n);
    usb_peer_model peer (.clk, .act, .cableAttachSeen, .cableDetachSeen, .wakeupRequestSeen,
        .chirpGoodSeen, .chirpBadSeen);
    always #10 clk = ~clk;
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // classic single cycle; waits for ack or err, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= {22'h0, i, 2'h0};
        wb_dat_i <= {24'h0, d};
        do @(posedge clk); while (!(wb_ack_o || wb_err_o));
        q = wb_dat_o[7:0];
        e = wb_err_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] exp);
        wb(1'b0, i, 8'h00);
        chk(q, exp);
    endtask
    // one cycle of event kind k, then time for the cause and interrupt to settle
    task automatic pulse(input logic [3:0] kd, input logic [3:0] ax);
        @(posedge clk);
        case (kd)
            4'h6: {automaticStateRequest, autoStateDoneOk} <= {ax, 1'b1};
            4'h7: transferEnd <= ax[2:0];
            4'h8: joinedHoldsData <= 1'b1;
            4'h9: joinedFull <= 1'b1;
            4'ha: joinedEmpty <= 1'b1;
            default: act <= kd[2:0];
        endcase
        @(posedge clk);
        {act, autoStateDoneOk, transferEnd, joinedHoldsData, joinedFull, joinedEmpty} <= '0;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        for (int j = 0; j < 6; j++) rd(IDXS[j], RESET_EVENT);
        wb(1'b0, 8'h10, 8'h00);
        chk({7'h0, e}, 8'h01);
        $display("test reset done");
        for (int i = 0; i < 17; i++) begin
            {k, a, ix, ex} = {ROWS[i][27:24], ROWS[i][19:0]};
            {linkSpeedSetting, hostBusState} <= ROWS[i][23:20];
            pulse(k, a);
            wb(1'b1, ix, 8'h00);
            rd(ix, ex);
            wb(1'b1, ix, 8'hff);
            rd(ix, 8'h00);
            $display("test row %0d done", i);
        end
        wb(1'b1, IDX_PORT_ENABLE_0, 8'h10);
        pulse(4'h1, 4'h0);
        chk({7'h0, interruptOut_n}, 8'h00);
        // firmware clears the cause before it drops the enable
        wb(1'b1, IDX_PORT_EVENT_0, 8'hff);
        repeat (2) @(posedge clk);
        chk({7'h0, interruptOut_n}, 8'h01);
        wb(1'b1, IDX_PORT_ENABLE_0, 8'h00);
        pulse(4'h1, 4'h0);
        chk({7'h0, interruptOut_n}, 8'h01);
        $display("test interrupt done");
        pllRunningState <= 1'b1;
        wb(1'b1, IDX_PORT_EVENT_0, 8'hff);
        rd(IDX_PORT_EVENT_0, 8'h10);
        {pllRunningState, deviceActiveState} <= 2'b01;
        pulse(4'h6, AUTO_GO_RESET);
        wb(1'b1, IDX_PORT_EVENT_1, 8'hff);
        rd(IDX_PORT_EVENT_1, 8'h01);
        deviceActiveState <= 1'b0;
        wb(1'b1, IDX_PORT_EVENT_0, 8'hff);
        wb(1'b1, IDX_PORT_EVENT_1, 8'hff);
        rd(IDX_PORT_EVENT_1, 8'h00);
        $display("test clear lock done");
        transferDirIn <= 3'h1;
        pulse(4'h7, 4'h1);
        rd(IDX_BUFFER_EVENT, 8'h00);
        engineBufferEmpty <= 3'h7;
        repeat (4) @(posedge clk);
        rd(IDX_BUFFER_EVENT, 8'h10);
        joinedHoldsData <= 1'b1;
        wb(1'b1, IDX_BUFFER_EVENT, 8'hff);
        rd(IDX_BUFFER_EVENT, 8'h04);
        $display("test drain and priority done");
        // deselected buffer no longer sets, and a write without lane 0 clears nothing
        statusJoinSelect <= 1'b0;
        wb_sel_i <= 4'h0;
        wb(1'b1, IDX_BUFFER_EVENT, 8'hff);
        rd(IDX_BUFFER_EVENT, 8'h04);
        wb_sel_i <= 4'h1;
        wb(1'b1, IDX_BUFFER_EVENT, 8'hff);
        rd(IDX_BUFFER_EVENT, 8'h00);
        $display("test select and lanes done");
        conclude();
    end
endmodule
bind usb_host_event_status host_event_checker checker_i (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .interruptOut_n);
`default_nettype wire
